// >>> verilog/nid_display.sv
// node id assignment, event history, status indicators and 7-segment display
`timescale 1ns/10ps
`default_nettype none
module nid_display
  import nid_pkg::*;
#(
  parameter int LONG_PRESS_CYC = NID_LONG_PRESS_CYC,
  parameter int FLASH_CYC = NID_FLASH_CYC,
  parameter int HIST_DEPTH = NID_HIST_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [3:0] bcd_switch,
  input wire logic button,
  input wire logic rx_valid,
  input wire nid_frame_t rx_frame,
  input wire logic nmt_reset_comm,
  input wire logic nmt_reset_node,
  input wire logic error_reset_cmd,
  input wire logic [7:0] nv_node_id,
  input wire logic ev_valid,
  input wire nid_event_t ev_in,
  input wire logic switch_on_cmd,
  input wire logic auto_power_en,
  input wire logic in_init,
  input wire logic link_overvolt,
  input wire logic aux_ok,
  input wire logic bus_supply_ok,
  input wire logic safety_a_ok,
  input wire logic safety_b_ok,
  input wire logic can_active,
  input wire logic can_error,
  output logic [7:0] node_id,
  output logic [7:0] proposed_id,
  output logic id_set_mode,
  output logic comm_enable,
  output logic nv_store,
  output logic switch_on_accept,
  output logic emcy_valid,
  output nid_event_t emcy_out,
  output logic error_active,
  output nid_leds_t leds,
  output nid_disp_t disp
);
  localparam int SEL_W = $clog2(HIST_DEPTH + 1);
  localparam logic [SEL_W-1:0] SEL_ID = '0;
  localparam logic [SEL_W-1:0] SEL_NEWEST = SEL_W'(1);

  logic boot_reg;
  logic [7:0] node_id_reg;
  logic [7:0] proposed_reg;
  logic id_mode_reg;
  logic nv_store_reg;
  logic sw_acc_reg;
  logic emcy_valid_reg;
  nid_event_t emcy_reg;
  logic err_active_reg;
  logic fault_seen_reg;
  logic btn_prev_reg;
  logic [31:0] hold_cnt_reg;
  logic long_done_reg;
  logic [31:0] flash_cnt_reg;
  logic flash_reg;
  logic [SEL_W-1:0] sel_reg;
  logic [SEL_W-1:0] hist_cnt_reg;
  nid_event_t hist_reg [HIST_DEPTH];
  nid_leds_t leds_reg;
  nid_disp_t disp_reg;
  nid_disp_t disp_next;

  logic press;
  logic long_press;
  logic frame_ok;
  logic [7:0] load_id;

  assign press = button && !btn_prev_reg;
  assign long_press = button && !long_done_reg && (hold_cnt_reg == 32'(LONG_PRESS_CYC - 1));

  // bytes 0..3 must all be zero, and only a zero switch lets the bus assign
  assign frame_ok = rx_valid && (rx_frame.cob == NID_SET_COB)
                    && (rx_frame.data[NID_ZERO_BYTES-1:0] == '0)
                    && (bcd_switch == 4'h0);

  // a nonzero stored id wins at switch zero; switch 1 to 9 adds to the default, anything else gives the default
  always_comb begin
    if (bcd_switch != 4'h0 && bcd_switch <= NID_SW_MAX) begin
      load_id = NID_DEFAULT_ID + {4'h0, bcd_switch};
    end else if (bcd_switch == 4'h0 && nv_node_id != 8'h00) begin
      load_id = nv_node_id;
    end else begin
      load_id = NID_DEFAULT_ID;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // the live id only moves at power-up or on reset-node
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      node_id_reg <= NID_DEFAULT_ID;
    end else if (boot_reg || nmt_reset_node) begin
      node_id_reg <= load_id;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      id_mode_reg <= 1'b0;
      proposed_reg <= 8'h00;
    end else if (frame_ok && !id_mode_reg) begin
      id_mode_reg <= 1'b1;
      proposed_reg <= rx_frame.data[NID_ID_BYTE];
    end else if (id_mode_reg && (press || nmt_reset_comm)) begin
      id_mode_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nv_store_reg <= 1'b0;
    end else begin
      nv_store_reg <= id_mode_reg && press && !nmt_reset_comm;
    end
  end

  // the master's switch-on only counts with auto power-on and normal comms
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_acc_reg <= 1'b0;
    end else begin
      sw_acc_reg <= switch_on_cmd && auto_power_en && !id_mode_reg;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      emcy_valid_reg <= 1'b0;
      emcy_reg <= '0;
    end else begin
      emcy_valid_reg <= ev_valid;
      if (ev_valid) begin
        emcy_reg <= ev_in;
      end
    end
  end

  // no local clear path; a new error in the clearing cycle stays set
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_active_reg <= 1'b0;
    end else if (ev_valid && ev_in.is_error) begin
      err_active_reg <= 1'b1;
    end else if (nmt_reset_comm || nmt_reset_node || error_reset_cmd) begin
      err_active_reg <= 1'b0;
    end
  end

  // any new event turns the run indicator red until the bus clears it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_seen_reg <= 1'b0;
    end else if (ev_valid) begin
      fault_seen_reg <= 1'b1;
    end else if (nmt_reset_comm || nmt_reset_node || error_reset_cmd) begin
      fault_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      btn_prev_reg <= 1'b0;
    end else begin
      btn_prev_reg <= button;
    end
  end

  // long press fires once per hold, so a held button does not repeat
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_reg <= 32'h0;
      long_done_reg <= 1'b0;
    end else if (!button) begin
      hold_cnt_reg <= 32'h0;
      long_done_reg <= 1'b0;
    end else if (long_press) begin
      long_done_reg <= 1'b1;
    end else if (!long_done_reg) begin
      hold_cnt_reg <= hold_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_cnt_reg <= 32'h0;
      flash_reg <= 1'b0;
    end else if (flash_cnt_reg == 32'(FLASH_CYC - 1)) begin
      flash_cnt_reg <= 32'h0;
      flash_reg <= !flash_reg;
    end else begin
      flash_cnt_reg <= flash_cnt_reg + 32'h1;
    end
  end

  // newest event at index 0, oldest falls off the end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_cnt_reg <= '0;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_reg[i] <= '0;
      end
    end else if (ev_valid) begin
      hist_reg[0] <= ev_in;
      for (int i = 1; i < HIST_DEPTH; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
      if (hist_cnt_reg != SEL_W'(HIST_DEPTH)) begin
        hist_cnt_reg <= hist_cnt_reg + SEL_W'(1);
      end
    end
  end

  // selection 0 is the id, 1..count are stored events
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg <= SEL_ID;
    end else if (ev_valid) begin
      sel_reg <= SEL_NEWEST;
    end else if (long_press) begin
      sel_reg <= SEL_ID;
    end else if (press && !id_mode_reg) begin
      if (sel_reg >= hist_cnt_reg) begin
        sel_reg <= SEL_ID;
      end else begin
        sel_reg <= sel_reg + SEL_W'(1);
      end
    end
  end

  function automatic logic [15:0] to_bcd(input logic [7:0] v);
    logic [7:0] h;
    logic [7:0] t;
    logic [7:0] u;
    h = v / 8'd100;
    t = (v % 8'd100) / 8'd10;
    u = v % 8'd10;
    return {4'h0, h[3:0], t[3:0], u[3:0]};
  endfunction

  always_comb begin
    disp_next = '0;
    if (id_mode_reg) begin
      disp_next.digits = to_bcd(proposed_reg);
      disp_next.blank = flash_reg;
    end else if (sel_reg == SEL_ID || sel_reg > hist_cnt_reg) begin
      disp_next.digits = to_bcd(node_id_reg);
    end else begin
      disp_next.digits = hist_reg[sel_reg - SEL_NEWEST].code;
      disp_next.err_dot = hist_reg[sel_reg - SEL_NEWEST].is_error;
      disp_next.warn_dot = !hist_reg[sel_reg - SEL_NEWEST].is_error;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_reg <= '0;
    end else begin
      disp_reg <= disp_next;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      leds_reg <= '0;
    end else begin
      leds_reg.run_red <= fault_seen_reg || err_active_reg;
      leds_reg.run_green <= !in_init && !fault_seen_reg && !err_active_reg;
      leds_reg.link_voltage_indicator <= !link_overvolt || flash_reg;
      leds_reg.aux_supply_indicator <= aux_ok;
      leds_reg.bus_supply_indicator <= bus_supply_ok;
      leds_reg.safety_indicator <= (safety_a_ok && safety_b_ok)
                                   || ((safety_a_ok ^ safety_b_ok) && flash_reg);
      leds_reg.can_red <= can_error;
      leds_reg.can_green <= !can_error && can_active && flash_reg;
    end
  end

  assign node_id = node_id_reg;
  assign proposed_id = proposed_reg;
  assign id_set_mode = id_mode_reg;
  assign comm_enable = !id_mode_reg;
  assign nv_store = nv_store_reg;
  assign switch_on_accept = sw_acc_reg;
  assign emcy_valid = emcy_valid_reg;
  assign emcy_out = emcy_reg;
  assign error_active = err_active_reg;
  assign leds = leds_reg;
  assign disp = disp_reg;

  chk_bad_frame: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rx_valid && !id_mode_reg && rx_frame.data[NID_ZERO_BYTES-1:0] != '0) |=> !id_mode_reg)
    else $error("frame with nonzero lead bytes entered setting mode");
  chk_switch_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    (rx_valid && !id_mode_reg && bcd_switch != 4'h0) |=> !id_mode_reg)
    else $error("setting mode entered with nonzero switch");
  chk_switch_id: assert property (@(posedge core_clk) disable iff (!reset_n)
    (nmt_reset_node && bcd_switch == 4'h3) |=> node_id == 8'd113)
    else $error("switch derived id wrong");
  chk_accept_exit: assert property (@(posedge core_clk) disable iff (!reset_n)
    (id_mode_reg && button && !btn_prev_reg && !nmt_reset_comm) |=> (!id_set_mode && nv_store))
    else $error("button did not confirm id");
  chk_mode_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (id_mode_reg && !press && !nmt_reset_comm) |=> id_set_mode)
    else $error("setting mode left without cause");
  chk_no_comm: assert property (@(posedge core_clk) disable iff (!reset_n)
    id_set_mode |-> !comm_enable ##1 !switch_on_accept)
    else $error("communication while in setting mode");
  chk_id_stable: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!boot_reg && !nmt_reset_node) |=> $stable(node_id))
    else $error("node id changed without reset node");
  chk_power_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    switch_on_accept |-> $past(auto_power_en) && $past(switch_on_cmd))
    else $error("switch-on accepted without auto power-on");
  chk_event_red: assert property (@(posedge core_clk) disable iff (!reset_n)
    ev_valid |=> emcy_valid && sel_reg == SEL_NEWEST ##1 leds.run_red)
    else $error("new event not shown and reported");
  chk_err_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
    (error_active && !nmt_reset_comm && !nmt_reset_node && !error_reset_cmd) |=> error_active)
    else $error("active error cleared locally");
  chk_long_home: assert property (@(posedge core_clk) disable iff (!reset_n)
    (long_press && !ev_valid) |=> sel_reg == SEL_ID)
    else $error("long press did not return to node id");
  chk_supply_leds: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!aux_ok && !bus_supply_ok) |=> (!leds.aux_supply_indicator && !leds.bus_supply_indicator))
    else $error("supply indicator lit without supply");
endmodule
`default_nettype wire

// >>> verilog/nid_pkg.sv
// constants and carrier types for the node id and status display block
// Operation
// - default node id is 110; id settings are readable as outputs.
// - switch at zero lets the bus assign the node id.
// - switch at 1 to 9 gives node id 110 plus switch value.
// - assignment frame id 0x7f2, bytes 0-3 zero, new id follows; else ignored.
// - assignment frame ignored whenever the switch is not zero.
// - accepted frame enters setting mode, proposed id blinks on display.
// - button press in setting mode confirms the proposed id.
// - setting mode ends only on button accept or reset-communication.
// - no normal bus communication while in setting mode.
// - reset-communication leaves setting mode, nothing else changes; the code also clears the active error and the red run indicator.
// - accepted id takes effect only after power cycle or reset-node.
// - switch-on command accepted only with automatic power-on enabled.
// - run indicator green normal, dark in init, red on active error.
// - link voltage indicator green, flashing slowly on overvoltage.
// - aux and bus supply indicators green when present, dark otherwise.
// - bus indicator flashes green on traffic, steady red on bus error.
// - id shown decimal no dot; codes 4-digit hex with type dot.
// - keep last 6 events; button steps cyclically id, warnings, errors.
// - holding button 3 seconds returns display to the node id.
// - new event shown at once, red run, emergency sent, logged.
// - no local clear; active error cleared by nmt reset or bus command.
package nid_pkg;
  localparam logic [7:0] NID_DEFAULT_ID = 8'h6e;
  localparam logic [10:0] NID_SET_COB = 11'h7f2;
  localparam int NID_ZERO_BYTES = 4;
  localparam int NID_ID_BYTE = 4;
  localparam int NID_HIST_DEPTH = 6;
  localparam logic [3:0] NID_SW_MAX = 4'h9;
  localparam longint NID_CLK_HZ = 250000000;
  localparam longint NID_LONG_PRESS_MS = 3000;
  localparam longint NID_FLASH_HALF_MS = 500;
  localparam int NID_LONG_PRESS_CYC = int'(NID_LONG_PRESS_MS * NID_CLK_HZ / 1000);
  localparam int NID_FLASH_CYC = int'(NID_FLASH_HALF_MS * NID_CLK_HZ / 1000);

  typedef struct packed {
    logic [10:0] cob;
    logic [5:0][7:0] data;
  } nid_frame_t;

  typedef struct packed {
    logic is_error;
    logic [15:0] code;
  } nid_event_t;

  typedef struct packed {
    logic [15:0] digits;
    logic warn_dot;
    logic err_dot;
    logic blank;
  } nid_disp_t;

  typedef struct packed {
    logic run_green;
    logic run_red;
    logic link_voltage_indicator;
    logic aux_supply_indicator;
    logic bus_supply_indicator;
    logic safety_indicator;
    logic can_green;
    logic can_red;
  } nid_leds_t;
endpackage

// >>> dv/nid_master_model.sv
// bus master model: id assignment frames and nmt and command pulses
`timescale 1ns/10ps
`default_nettype none
module nid_master_model
  import nid_pkg::*;
(
  input wire logic core_clk,
  output logic rx_valid,
  output nid_frame_t rx_frame,
  output logic nmt_reset_comm,
  output logic nmt_reset_node,
  output logic error_reset_cmd,
  output logic switch_on_cmd
);
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    nmt_reset_comm = 1'b0;
    nmt_reset_node = 1'b0;
    error_reset_cmd = 1'b0;
    switch_on_cmd = 1'b0;
  end
  // payload inverted after the frame so nothing can live off a stale frame
  task automatic send_frame(input logic [10:0] cob, input logic [31:0] lead,
                            input logic [7:0] id);
    @(negedge core_clk);
    rx_frame.cob = cob;
    rx_frame.data = {8'h00, id, lead};
    rx_valid = 1'b1;
    @(negedge core_clk);
    rx_valid = 1'b0;
    rx_frame = ~rx_frame;
  endtask
  // 0 reset comm, 1 reset node, 2 error reset, 3 switch on
  task automatic pulse(input int k);
    @(negedge core_clk);
    case (k)
      0: nmt_reset_comm = 1'b1;
      1: nmt_reset_node = 1'b1;
      2: error_reset_cmd = 1'b1;
      default: switch_on_cmd = 1'b1;
    endcase
    @(negedge core_clk);
    nmt_reset_comm = 1'b0;
    nmt_reset_node = 1'b0;
    error_reset_cmd = 1'b0;
    switch_on_cmd = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/node_id_and_status_display_tb_top.sv
// self-checking bench for the node id and status display block
`timescale 1ns/10ps
`default_nettype none
module node_id_and_status_display_tb_top
  import nid_pkg::*;
;
  logic core_clk, reset_n, button, ev_valid, auto_power_en, in_init, link_overvolt;
  logic aux_ok, bus_supply_ok, safety_a_ok, safety_b_ok, can_active, can_error;
  logic rx_valid, nmt_reset_comm, nmt_reset_node, error_reset_cmd, switch_on_cmd;
  logic [3:0] bcd_switch;
  logic [7:0] nv_node_id, node_id, proposed_id;
  logic id_set_mode, comm_enable, nv_store, switch_on_accept, emcy_valid, error_active;
  nid_frame_t rx_frame;
  nid_event_t ev_in, emcy_out;
  nid_leds_t leds;
  nid_disp_t disp;
  int errors = 0;
  int checked = 0;

  nid_master_model nid_master_model_inst (.core_clk(core_clk), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .nmt_reset_comm(nmt_reset_comm), .nmt_reset_node(nmt_reset_node),
    .error_reset_cmd(error_reset_cmd), .switch_on_cmd(switch_on_cmd));
  // short counts keep the long press and flash periods within a quick run
  nid_display #(.LONG_PRESS_CYC(20), .FLASH_CYC(4), .HIST_DEPTH(6)) nid_display_inst (
    .core_clk(core_clk), .reset_n(reset_n), .bcd_switch(bcd_switch), .button(button),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .nmt_reset_comm(nmt_reset_comm),
    .nmt_reset_node(nmt_reset_node), .error_reset_cmd(error_reset_cmd),
    .nv_node_id(nv_node_id), .ev_valid(ev_valid), .ev_in(ev_in),
    .switch_on_cmd(switch_on_cmd), .auto_power_en(auto_power_en), .in_init(in_init),
    .link_overvolt(link_overvolt), .aux_ok(aux_ok), .bus_supply_ok(bus_supply_ok),
    .safety_a_ok(safety_a_ok), .safety_b_ok(safety_b_ok), .can_active(can_active),
    .can_error(can_error), .node_id(node_id), .proposed_id(proposed_id),
    .id_set_mode(id_set_mode), .comm_enable(comm_enable), .nv_store(nv_store),
    .switch_on_accept(switch_on_accept), .emcy_valid(emcy_valid), .emcy_out(emcy_out),
    .error_active(error_active), .leds(leds), .disp(disp));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    chk_word(n, {8'h00, e}, {8'h00, g});
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    chk_word(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one full flash period sampled at the falling edge; a square wave gives four lit samples
  task automatic count_on(input nid_leds_t m, input logic blank_sel, output int n);
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      n += blank_sel ? int'(disp.blank) : int'(|(leds & m));
    end
  endtask
  task automatic press();
    @(negedge core_clk);
    button = 1'b1;
    @(negedge core_clk);
    button = 1'b0;
  endtask

  task automatic t_default();
    cycles(2);
    chk_byte("node_id", 8'h6e, node_id);
    chk_bit("comm_enable", 1'b1, comm_enable);
    bcd_switch = 4'h3;
    nid_master_model_inst.pulse(1);
    chk_byte("node_id", 8'h71, node_id);
    bcd_switch = 4'h9;
    nid_master_model_inst.pulse(1);
    chk_byte("node_id", 8'h77, node_id);
    bcd_switch = 4'h0;
    nid_master_model_inst.pulse(1);
    chk_byte("node_id", 8'h6e, node_id);
    $display("test default done");
  endtask

  task automatic t_refuse();
    nid_master_model_inst.send_frame(NID_SET_COB, 32'h0000_0100, 8'h2a);
    chk_bit("id_set_mode", 1'b0, id_set_mode);
    bcd_switch = 4'h5;
    nid_master_model_inst.send_frame(NID_SET_COB, 32'h0, 8'h2a);
    chk_bit("id_set_mode", 1'b0, id_set_mode);
    bcd_switch = 4'h0;
    $display("test refuse done");
  endtask

  task automatic t_assign();
    int n;
    nid_master_model_inst.send_frame(NID_SET_COB, 32'h0, 8'h2a);
    chk_bit("id_set_mode", 1'b1, id_set_mode);
    chk_byte("proposed_id", 8'h2a, proposed_id);
    chk_bit("comm_enable", 1'b0, comm_enable);
    count_on('0, 1'b1, n);
    chk_byte("blank_flash", 8'd4, 8'(n));
    chk_word("disp_digits", 16'h0042, disp.digits);
    chk_bit("id_set_mode", 1'b1, id_set_mode);
    nid_master_model_inst.pulse(0);
    chk_bit("id_set_mode", 1'b0, id_set_mode);
    chk_byte("node_id", 8'h6e, node_id);
    nid_master_model_inst.send_frame(NID_SET_COB, 32'h0, 8'h2a);
    press();
    chk_bit("id_set_mode", 1'b0, id_set_mode);
    chk_bit("nv_store", 1'b1, nv_store);
    chk_byte("node_id", 8'h6e, node_id);
    nv_node_id = 8'h2a;
    nid_master_model_inst.pulse(1);
    chk_byte("node_id", 8'h2a, node_id);
    $display("test assign done");
  endtask

  // a warning and then an error, each shown at once with its own dot
  task automatic t_event(input logic is_err, input logic [15:0] code);
    @(negedge core_clk);
    ev_valid = 1'b1;
    ev_in = '{is_error: is_err, code: code};
    @(negedge core_clk);
    ev_valid = 1'b0;
    chk_bit("emcy_valid", 1'b1, emcy_valid);
    chk_word("emcy_code", code, emcy_out.code);
    chk_bit("emcy_type", is_err, emcy_out.is_error);
    chk_bit("error_active", is_err, error_active);
    cycles(1);
    chk_word("disp_digits", code, disp.digits);
    chk_bit("err_dot", is_err, disp.err_dot);
    chk_bit("warn_dot", ~is_err, disp.warn_dot);
    chk_bit("run_red", 1'b1, leds.run_red);
    $display("test event done");
  endtask

  task automatic t_long_press();
    @(negedge core_clk);
    button = 1'b1;
    cycles(2);
    chk_word("disp_digits", 16'h5a31, disp.digits);
    chk_bit("warn_dot", 1'b1, disp.warn_dot);
    cycles(23);
    button = 1'b0;
    cycles(1);
    chk_word("disp_digits", 16'h0110, disp.digits);
    chk_bit("err_dot", 1'b0, disp.err_dot);
    chk_bit("error_active", 1'b1, error_active);
    nid_master_model_inst.pulse(2);
    cycles(1);
    chk_bit("error_active", 1'b0, error_active);
    chk_bit("run_red", 1'b0, leds.run_red);
    $display("test long press done");
  endtask

  task automatic t_switch_on();
    nid_master_model_inst.pulse(3);
    chk_bit("switch_on_accept", 1'b0, switch_on_accept);
    auto_power_en = 1'b1;
    nid_master_model_inst.pulse(3);
    chk_bit("switch_on_accept", 1'b1, switch_on_accept);
    $display("test switch on done");
  endtask

  task automatic t_leds();
    int n;
    aux_ok = 1'b0;
    can_error = 1'b1;
    cycles(2);
    chk_bit("aux_led", 1'b0, leds.aux_supply_indicator);
    chk_bit("bus_supply_led", 1'b1, leds.bus_supply_indicator);
    chk_bit("can_red", 1'b1, leds.can_red);
    chk_bit("run_green", 1'b1, leds.run_green);
    chk_bit("link_led", 1'b1, leds.link_voltage_indicator);
    chk_bit("safety_led", 1'b1, leds.safety_indicator);
    in_init = 1'b1;
    cycles(2);
    chk_bit("run_green", 1'b0, leds.run_green);
    bus_supply_ok = 1'b0;
    link_overvolt = 1'b1;
    safety_b_ok = 1'b0;
    can_error = 1'b0;
    can_active = 1'b1;
    cycles(2);
    chk_bit("bus_supply_led", 1'b0, leds.bus_supply_indicator);
    chk_bit("can_red", 1'b0, leds.can_red);
    count_on(nid_leds_t'{link_voltage_indicator: 1'b1, default: 1'b0}, 1'b0, n);
    chk_byte("link_flash", 8'd4, 8'(n));
    count_on(nid_leds_t'{safety_indicator: 1'b1, default: 1'b0}, 1'b0, n);
    chk_byte("safety_flash", 8'd4, 8'(n));
    count_on(nid_leds_t'{can_green: 1'b1, default: 1'b0}, 1'b0, n);
    chk_byte("can_flash", 8'd4, 8'(n));
    safety_a_ok = 1'b0;
    cycles(2);
    chk_bit("safety_led", 1'b0, leds.safety_indicator);
    $display("test leds done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    bcd_switch = 4'h0;
    button = 1'b0;
    nv_node_id = 8'h00;
    ev_valid = 1'b0;
    ev_in = '0;
    auto_power_en = 1'b0;
    in_init = 1'b0;
    link_overvolt = 1'b0;
    aux_ok = 1'b1;
    bus_supply_ok = 1'b1;
    safety_a_ok = 1'b1;
    safety_b_ok = 1'b1;
    can_active = 1'b0;
    can_error = 1'b0;
    cycles(3);
    reset_n = 1'b1;
    t_default();
    t_refuse();
    t_event(1'b0, 16'h5a31);
    t_event(1'b1, 16'hbe21);
    t_long_press();
    t_switch_on();
    t_leds();
    t_assign();
    final_report();
  end
endmodule
`default_nettype wire
